/* File: hdl/smbip_dev.sv */
`timescale 1ns/1ps
module smbip_dev
    import smbip_pkg::*;
#(
    parameter int REG_N = 16,
    parameter logic [7:0] COUNT_RST = 8'h00
)(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    smbip_if.dev link,
    output logic upd_valid_o,
    output logic [7:0] upd_index_o,
    output logic [7:0] upd_data_o
);
    localparam int IW = $clog2(REG_N);
    localparam logic [IW-1:0] CI = IW'(CNT_IDX);

    logic [7:0] mem [REG_N];
    smbip_dst_e st;
    smbip_dst_e nxt;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] idx;
    logic [7:0] left;
    logic [7:0] rx_byte;
    logic samp;
    logic sda_oe;
    logic ack_now;
    logic start;
    logic stop;
    logic wr_go;
    logic lrst_a;
    logic lrst;
    logic upd_tgl;
    logic [7:0] upd_idx;
    logic [7:0] upd_dat;
    logic tg_a;
    logic tg_b;
    logic tg_c;

    // ----------------------------------------
    // Link domain
    // ----------------------------------------
    // Reset crossing; the host keeps the clock toggling while in reset
    always_ff @(negedge link.scl)
    begin
        lrst_a <= rst_i;
        lrst <= lrst_a;
    end

    // Data is taken at the rising edge of each bit
    always_ff @(posedge link.scl)
    begin
        samp <= link.sda;
    end

    // A data line change inside one high phase is a start or a stop
    assign start = samp & ~link.sda;
    assign stop = ~samp & link.sda;
    assign rx_byte = {sh[6:0], samp};

    // Decision on a fully received byte
    always_comb
    begin
        ack_now = 1'b0;
        nxt = D_IDLE;
        case (st)
            D_ADDR:
            begin
                // R16: foreign addresses
                if (rx_byte == ADDR_WR)
                begin
                    ack_now = 1'b1;
                    nxt = D_INDEX;
                end
                // R10: read address acked
                else if (rx_byte == ADDR_RD)
                begin
                    ack_now = 1'b1;
                    nxt = D_TXC;
                end
            end
            // R2: index and count acked
            D_INDEX:
            begin
                ack_now = 1'b1;
                nxt = D_COUNT;
            end
            D_COUNT:
            begin
                ack_now = 1'b1;
                nxt = D_WDATA;
            end
            // R6: ack each data byte
            D_WDATA:
            begin
                ack_now = (left != 8'h00);
                nxt = (left != 8'h00) ? D_WDATA : D_IDLE;
            end
            default:
            begin
                ack_now = 1'b0;
                nxt = D_IDLE;
            end
        endcase
    end

    assign wr_go = !start && !stop && st == D_WDATA && bitc == BIT_LAST && left != 8'h00;

    // Protocol engine; all changes happen with the clock low
    always_ff @(negedge link.scl)
    begin
        if (lrst)
        begin
            st <= D_IDLE;
            bitc <= 4'h0;
            sh <= 8'h00;
            idx <= 8'h00;
            left <= 8'h00;
            sda_oe <= 1'b0;
        end
        // Start wins over everything but reset, including a repeated start
        else if (start)
        begin
            st <= D_ADDR;
            bitc <= 4'h0;
            sda_oe <= 1'b0;
        end
        // R16: stop returns idle
        else if (stop)
        begin
            st <= D_IDLE;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (st)
                D_IDLE:
                begin
                    sda_oe <= 1'b0;
                end
                // R11: count goes first
                // R13: count from byte eight
                D_TXC:
                begin
                    st <= D_TX;
                    sh <= mem[CI];
                    left <= mem[CI];
                    bitc <= 4'h0;
                    sda_oe <= ~mem[CI][7];
                end
                D_TX:
                begin
                    if (bitc < BIT_LAST)
                    begin
                        sh <= {sh[6:0], 1'b0};
                        bitc <= bitc + 4'h1;
                        sda_oe <= ~sh[6];
                    end
                    else if (bitc == BIT_LAST)
                    begin
                        bitc <= BIT_ACK;
                        sda_oe <= 1'b0;
                    end
                    // R12: ascending bytes from index
                    else if (!samp && left != 8'h00)
                    begin
                        sh <= mem[idx[IW-1:0]];
                        sda_oe <= ~mem[idx[IW-1:0]][7];
                        idx <= idx + 8'h01;
                        left <= left - 8'h01;
                        bitc <= 4'h0;
                    end
                    // A not-acknowledge or an exhausted count ends the read
                    else
                    begin
                        st <= D_IDLE;
                    end
                end
                default:
                begin
                    if (bitc < BIT_LAST)
                    begin
                        sh <= rx_byte;
                        bitc <= bitc + 4'h1;
                    end
                    else if (bitc == BIT_LAST)
                    begin
                        // R2: drive ack slot
                        bitc <= BIT_ACK;
                        sda_oe <= ack_now;
                        st <= nxt;
                        if (st == D_INDEX)
                        begin
                            idx <= rx_byte;
                        end
                        if (st == D_COUNT)
                        begin
                            left <= rx_byte;
                        end
                        // R7: advance write index
                        if (wr_go)
                        begin
                            idx <= idx + 8'h01;
                            left <= left - 8'h01;
                        end
                    end
                    else
                    begin
                        bitc <= 4'h0;
                        sda_oe <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Configuration bytes; writes beyond the stated count are refused
    always_ff @(negedge link.scl)
    begin
        if (lrst)
        begin
            for (int i = 0; i < REG_N; i++)
            begin
                mem[i] <= (i == CNT_IDX) ? COUNT_RST : 8'h00;
            end
        end
        // R7: store at index
        else if (wr_go)
        begin
            mem[idx[IW-1:0]] <= rx_byte;
        end
    end

    // Update event towards the system side, held until the next write
    always_ff @(negedge link.scl)
    begin
        if (lrst)
        begin
            upd_tgl <= 1'b0;
            upd_idx <= 8'h00;
            upd_dat <= 8'h00;
        end
        else if (wr_go)
        begin
            upd_tgl <= ~upd_tgl;
            upd_idx <= idx;
            upd_dat <= rx_byte;
        end
    end

    assign link.d_sda_o = 1'b0;
    assign link.d_sda_oe = sda_oe;

    // ----------------------------------------
    // System domain
    // ----------------------------------------
    // Toggle synchroniser
    always_ff @(posedge sys_clk_i)
    begin
        tg_a <= upd_tgl;
        tg_b <= tg_a;
    end

    // Index and data are stable for nine link clocks, so a late capture is safe
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            tg_c <= tg_b;
            upd_valid_o <= 1'b0;
            upd_index_o <= 8'h00;
            upd_data_o <= 8'h00;
        end
        else
        begin
            tg_c <= tg_b;
            upd_valid_o <= tg_b ^ tg_c;
            if (tg_b ^ tg_c)
            begin
                upd_index_o <= upd_idx;
                upd_data_o <= upd_dat;
            end
        end
    end
endmodule

/* File: hdl/smbip_host.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: Host opens write with start, address d2.
// R2: Device acks address, index and count bytes.
// R3: Host sends starting index after address.
// R4: Host sends byte count after index.
// R5: Host sends data bytes in ascending order.
// R6: Device acks each data byte.
// R7: Device stores bytes at successive indices.
// R8: Host ends write with stop.
// R9: Read opens with start, d2, index.
// R10: Repeated start, address d3, device acks.
// R11: Device returns byte count first.
// R12: Device returns bytes from index upward.
// R13: Read length comes from configuration byte eight.
// R14: Host acks every read byte but last.
// R15: Host nacks last byte, then stops.
// R16: Device ignores foreign addresses; stop idles.

// ----------------------------------------
// Write data buffer
// ----------------------------------------
module smbip_fifo
    import smbip_pkg::*;
#(
    parameter int WIDTH = BYTE_W,
    parameter int DEPTH = FIFO_DEPTH
)(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [AW:0] next_cnt;
    logic push;
    logic pop;

    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign next_cnt = cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    assign out_data_o = mem[rp];

    // Storage
    always_ff @(posedge sys_clk_i)
    begin
        if (push)
        begin
            mem[wp] <= in_data_i;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            wp <= '0;
            rp <= '0;
        end
        else
        begin
            if (push)
            begin
                wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1);
            end
            if (pop)
            begin
                rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1);
            end
        end
    end

    // Fill level and registered flags
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cnt <= '0;
            in_ready_o <= 1'b0;
            out_valid_o <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            in_ready_o <= (next_cnt != (AW + 1)'(DEPTH));
            out_valid_o <= (next_cnt != '0);
        end
    end
endmodule

// ----------------------------------------
// Bus host
// ----------------------------------------
module smbip_host
    import smbip_pkg::*;
#(
    parameter int QTR = QTR_CYC
)(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    smbip_if.host link,
    input wire logic cmd_valid_i,
    input wire logic cmd_read_i,
    input wire logic [7:0] cmd_index_i,
    input wire logic [7:0] cmd_count_i,
    output logic cmd_ready_o,
    input wire logic wr_valid_i,
    input wire logic [7:0] wr_data_i,
    output logic wr_ready_o,
    output logic rd_valid_o,
    output logic rd_count_o,
    output logic [7:0] rd_data_o,
    output logic done_o,
    output logic err_o
);
    smbip_hst_e st;
    logic [15:0] qcnt;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [7:0] left;
    logic [7:0] idx_r;
    logic rmode;
    logic ack_ok;
    logic scl_q;
    logic oe;
    logic next_oe;
    logic sda_a;
    logic sda_b;
    logic tick;
    logic active;
    logic is_tx;
    logic is_rx;
    logic slot_end;
    logic f_valid;
    logic [7:0] f_data;
    logic [2:0] rst_tail;

    assign is_tx = st inside {H_ADDR, H_INDEX, H_COUNT, H_WDATA, H_RADDR};
    assign is_rx = st inside {H_RCOUNT, H_RDATA};
    assign active = st != H_IDLE && st != H_WAIT;
    assign tick = (qcnt == 16'(QTR - 1));
    assign slot_end = active && tick && q == 2'h3;

    // Write data waits here; the engine stalls when it runs dry
    smbip_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_valid_i(wr_valid_i),
        .in_ready_o(wr_ready_o),
        .in_data_i(wr_data_i),
        .out_valid_o(f_valid),
        .out_ready_i(st == H_WAIT),
        .out_data_o(f_data)
    );

    // Data line synchroniser
    always_ff @(posedge sys_clk_i)
    begin
        sda_a <= link.sda;
        sda_b <= sda_a;
    end

    // Quarter-period timer
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || !active)
        begin
            qcnt <= 16'h0000;
            q <= 2'h0;
        end
        else if (tick)
        begin
            qcnt <= 16'h0000;
            q <= q + 2'h1;
        end
        else
        begin
            qcnt <= qcnt + 16'h0001;
        end
    end

    // Post-reset tail; the far end's reset synchroniser needs two falls after release,
    // otherwise the first start would still find it held in reset
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rst_tail <= RST_TAIL;
        end
        else if (rst_tail != 3'h0)
        begin
            rst_tail <= rst_tail - 3'h1;
        end
    end

    // Clock keeps toggling in reset and its tail so the far end can clear its state
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || rst_tail != 3'h0)
        begin
            if (scl_q)
            begin
                scl_q <= 1'b0;
            end
            else
            begin
                scl_q <= 1'b1;
            end
        end
        else if (st == H_IDLE)
        begin
            scl_q <= 1'b1;
        end
        else if (st == H_STOP)
        begin
            scl_q <= (q != 2'h0);
        end
        else
        begin
            scl_q <= (q == 2'h1 || q == 2'h2);
        end
    end

    // Data line drive per slot
    always_comb
    begin
        next_oe = 1'b0;
        case (st)
            // R1: start condition
            // R10: repeated start
            H_START, H_RSTART: next_oe = q[1];
            // R8: stop condition
            H_STOP: next_oe = ~q[1];
            // R14: ack all but last
            // R15: nack the last
            H_RCOUNT: next_oe = (bitn == BIT_ACK) && (rx_sh != 8'h00);
            H_RDATA: next_oe = (bitn == BIT_ACK) && (left != 8'h01);
            default: next_oe = is_tx && (bitn != BIT_ACK) && !tx_sh[7];
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            oe <= 1'b0;
        end
        else
        begin
            oe <= next_oe;
        end
    end

    assign link.scl = scl_q;
    assign link.h_sda_o = 1'b0;
    assign link.h_sda_oe = oe;

    // Sampling at the end of the high phase
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rx_sh <= 8'h00;
            ack_ok <= 1'b0;
        end
        else if (active && tick && q == 2'h2)
        begin
            if (is_rx && bitn != BIT_ACK)
            begin
                rx_sh <= {rx_sh[6:0], sda_b};
            end
            if (is_tx && bitn == BIT_ACK)
            begin
                ack_ok <= ~sda_b;
            end
        end
    end

    // Transfer sequencer
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            st <= H_IDLE;
            bitn <= 4'h0;
            tx_sh <= 8'h00;
            left <= 8'h00;
            idx_r <= 8'h00;
            rmode <= 1'b0;
            cmd_ready_o <= 1'b0;
            rd_valid_o <= 1'b0;
            rd_count_o <= 1'b0;
            rd_data_o <= 8'h00;
            done_o <= 1'b0;
            err_o <= 1'b0;
        end
        else
        begin
            rd_valid_o <= 1'b0;
            done_o <= 1'b0;
            if (st == H_IDLE)
            begin
                // No command while the reset tail still clocks the link
                cmd_ready_o <= (rst_tail == 3'h0);
                if (cmd_valid_i && cmd_ready_o)
                begin
                    cmd_ready_o <= 1'b0;
                    rmode <= cmd_read_i;
                    idx_r <= cmd_index_i;
                    left <= cmd_count_i;
                    err_o <= 1'b0;
                    bitn <= 4'h0;
                    st <= H_START;
                end
            end
            // R5: data in queue order
            else if (st == H_WAIT)
            begin
                if (f_valid)
                begin
                    tx_sh <= f_data;
                    left <= left - 8'h01;
                    bitn <= 4'h0;
                    st <= H_WDATA;
                end
            end
            else if (slot_end && (is_tx || is_rx) && bitn != BIT_ACK)
            begin
                bitn <= bitn + 4'h1;
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
            else if (slot_end)
            begin
                bitn <= 4'h0;
                // A refused byte aborts the transfer with a stop
                if (is_tx && !ack_ok)
                begin
                    err_o <= 1'b1;
                    st <= H_STOP;
                end
                else
                begin
                    case (st)
                        // R1: write address first
                        // R9: reads also open with it
                        H_START:
                        begin
                            tx_sh <= ADDR_WR;
                            st <= H_ADDR;
                        end
                        // R3: starting index
                        H_ADDR:
                        begin
                            tx_sh <= idx_r;
                            st <= H_INDEX;
                        end
                        // R4: count follows index
                        H_INDEX:
                        begin
                            tx_sh <= left;
                            st <= rmode ? H_RSTART : H_COUNT;
                        end
                        // R8: stop after last byte
                        H_COUNT, H_WDATA: st <= (left == 8'h00) ? H_STOP : H_WAIT;
                        // R10: read address
                        H_RSTART:
                        begin
                            tx_sh <= ADDR_RD;
                            st <= H_RADDR;
                        end
                        H_RADDR: st <= H_RCOUNT;
                        // R13: device sets the length
                        H_RCOUNT:
                        begin
                            rd_valid_o <= 1'b1;
                            rd_count_o <= 1'b1;
                            rd_data_o <= rx_sh;
                            left <= rx_sh;
                            st <= (rx_sh == 8'h00) ? H_STOP : H_RDATA;
                        end
                        // R15: stop after the nack
                        H_RDATA:
                        begin
                            rd_valid_o <= 1'b1;
                            rd_count_o <= 1'b0;
                            rd_data_o <= rx_sh;
                            left <= left - 8'h01;
                            st <= (left == 8'h01) ? H_STOP : H_RDATA;
                        end
                        H_STOP:
                        begin
                            done_o <= 1'b1;
                            st <= H_IDLE;
                        end
                        default: st <= H_IDLE;
                    endcase
                end
            end
        end
    end
endmodule

/* File: hdl/smbip_if.sv */
`timescale 1ns/1ps
interface smbip_if;
    // ----------------------------------------
    // Link wires
    // ----------------------------------------
    logic scl;
    logic h_sda_o;
    logic h_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic sda;

    // Data line is wired-and with a pull-up when nobody drives it low
    assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

    modport host (output scl, output h_sda_o, output h_sda_oe, input sda);
    modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface

/* File: hdl/smbip_pkg.sv */
package smbip_pkg;
    // ----------------------------------------
    // Bus addresses and byte layout
    // ----------------------------------------
    localparam logic [7:0] ADDR_WR = 8'hd2;
    localparam logic [7:0] ADDR_RD = 8'hd3;
    localparam int CNT_IDX = 8;
    localparam int BYTE_W = 8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam int FIFO_DEPTH = 8;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_NS = 20;
    localparam int SCL_PERIOD_NS = 10000;
    // Clock period splits into four equal quarters
    localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
    // Link clock toggles given after reset release: four toggles make two falls
    localparam logic [2:0] RST_TAIL = 3'h4;

    // ----------------------------------------
    // State machines
    // ----------------------------------------
    typedef enum {D_IDLE, D_ADDR, D_INDEX, D_COUNT, D_WDATA, D_TXC, D_TX} smbip_dst_e;
    typedef enum {H_IDLE, H_START, H_ADDR, H_INDEX, H_COUNT, H_WAIT, H_WDATA,
        H_RSTART, H_RADDR, H_RCOUNT, H_RDATA, H_STOP} smbip_hst_e;
endpackage

/* File: tb/smbip_checker.sv */
`timescale 1ns/1ps
module smbip_checker
    import smbip_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic scl,
    input wire logic h_sda_o,
    input wire logic h_sda_oe,
    input wire logic d_sda_o,
    input wire logic d_sda_oe,
    input wire logic sda
);
    logic scl_q;
    logic sda_q;
    logic rdm;
    logic [3:0] bc;
    logic [7:0] bn;
    logic [7:0] sh;
    logic [8:0] cnt;
    wire srise = scl & ~scl_q;
    wire strt = scl & scl_q & sda_q & ~sda;
    wire stp = scl & scl_q & ~sda_q & sda;
    wire ackb = srise & (bc == BIT_ACK);

    // Byte tracker; a start realigns it, so reset glitches on scl do no harm
    always_ff @(posedge sys_clk_i)
    begin
        scl_q <= scl;
        sda_q <= sda;
        if (rst_i || strt)
        begin
            bc <= 4'h0;
            bn <= 8'h00;
            rdm <= 1'b0;
        end
        else if (ackb)
        begin
            bc <= 4'h0;
            bn <= bn + 8'h01;
            if (bn == 8'h00)
                rdm <= (sh == ADDR_RD);
            if (bn == 8'h01)
                cnt <= {1'b0, sh};
        end
        else if (srise)
        begin
            bc <= bc + 4'h1;
            sh <= {sh[6:0], sda};
        end
    end

    // Protocol relations on the wire
    a_addr_own: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ackb && bn == 8'h00 |-> sh == ADDR_WR || sh == ADDR_RD)
        else $error("address byte not own");
    a_addr_ack: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ackb && bn == 8'h00 |-> !sda)
        else $error("address not acked");
    a_write_ack: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ackb && bn != 8'h00 && !rdm |-> !sda)
        else $error("written byte not acked");
    a_read_ack: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ackb && bn != 8'h00 && rdm
        |-> sda == ((bn == 8'h01) ? (sh == 8'h00) : ({1'b0, bn} == cnt + 9'h001)))
        else $error("read ack pattern wrong");
    a_dev_edge: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !$stable(d_sda_oe) |-> !scl)
        else $error("device moved sda while scl high");
    a_stop_free: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        stp |-> !d_sda_oe [*8])
        else $error("device drives after stop");
    a_rst_host: assert property (@(posedge sys_clk_i)
        rst_i |=> !h_sda_oe)
        else $error("host drives in reset");
    a_rst_dev: assert property (@(posedge sys_clk_i)
        rst_i [*8] ##1 rst_i [*8] |-> !d_sda_oe)
        else $error("device drives in reset");
endmodule

/* File: tb/smbip_indexed_block_port_bench.sv */
`timescale 1ns/1ps
module smbip_indexed_block_port_bench
    import smbip_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_i = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [7:0] cmd_index = 8'h00;
    logic [7:0] cmd_count = 8'h00;
    logic wr_valid = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic cmd_ready, wr_ready, rd_valid, rd_count, done, err, upd_valid;
    logic [7:0] rd_data, upd_index, upd_data;
    logic [7:0] mem [16] = '{default: 8'h00};
    logic [15:0] rq[$];
    logic [15:0] uq[$];
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 32'h575b;

    smbip_if lk();
    smbip_host #(.QTR(4)) i_smbip_host (.sys_clk_i(sys_clk), .rst_i(rst_i), .link(lk),
        .cmd_valid_i(cmd_valid), .cmd_read_i(cmd_read), .cmd_index_i(cmd_index),
        .cmd_count_i(cmd_count), .cmd_ready_o(cmd_ready), .wr_valid_i(wr_valid),
        .wr_data_i(wr_data), .wr_ready_o(wr_ready), .rd_valid_o(rd_valid),
        .rd_count_o(rd_count), .rd_data_o(rd_data), .done_o(done), .err_o(err));
    smbip_dev i_smbip_dev (.sys_clk_i(sys_clk), .rst_i(rst_i), .link(lk),
        .upd_valid_o(upd_valid), .upd_index_o(upd_index), .upd_data_o(upd_data));
    smbip_checker i_smbip_checker (.sys_clk_i(sys_clk), .rst_i(rst_i), .scl(lk.scl),
        .h_sda_o(lk.h_sda_o), .h_sda_oe(lk.h_sda_oe), .d_sda_o(lk.d_sda_o),
        .d_sda_oe(lk.d_sda_oe), .sda(lk.sda));

    always #10 sys_clk = ~sys_clk;

    task summarize;
        if (error_cnt == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (e !== g)
        begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask

    // Oldest note against each result; an empty queue gives x and so a mismatch
    always @(negedge sys_clk)
    begin
        if (rd_valid === 1'b1)
            cmp("rd", (rq.size() > 0) ? rq.pop_front() : 'x, {7'h00, rd_count, rd_data});
        if (upd_valid === 1'b1)
            cmp("upd", (uq.size() > 0) ? uq.pop_front() : 'x, {upd_index, upd_data});
    end

    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            summarize();
        end
    end

    task cmd(input logic rd, input logic [7:0] idx, input logic [7:0] n);
        @(posedge sys_clk);
        #1;
        cmd_read = rd;
        cmd_index = idx;
        cmd_count = n;
        cmd_valid = 1'b1;
        do @(negedge sys_clk); while (cmd_ready !== 1'b1);
        @(posedge sys_clk);
        #1 cmd_valid = 1'b0;
        do @(negedge sys_clk); while (done !== 1'b1);
        cmp("err", 16'h0000, {15'h0000, err});
    endtask

    // Bytes go to the FIFO first, so eight of them must fill it
    task wblk(input logic [7:0] idx, input int n, input logic [7:0] c8);
        logic [7:0] a;
        logic [7:0] d;
        @(posedge sys_clk);
        #1;
        for (int k = 0; k < n; k++)
        begin
            a = 8'((idx + k) % 16);
            d = (a == 8'h08) ? c8 : 8'($random(seed));
            mem[a[3:0]] = d;
            uq.push_back({a, d});
            wr_data = d;
            wr_valid = 1'b1;
            do @(negedge sys_clk); while (wr_ready !== 1'b1);
            @(posedge sys_clk);
            #1;
        end
        wr_valid = 1'b0;
        if (n == 8)
            cmp("full", 16'h0000, {15'h0000, wr_ready});
        cmd(1'b0, idx, 8'(n));
    endtask

    task rblk(input logic [7:0] idx);
        rq.push_back({8'h01, mem[8]});
        for (int k = 0; k < mem[8]; k++)
            rq.push_back({8'h00, mem[4'((idx + k) % 16)]});
        cmd(1'b1, idx, 8'h00);
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk);
        #1 rst_i = 1'b0;
        wblk(8'h07, 8, 8'h03);
        rblk(8'h07);
        wblk(8'h0d, 3, 8'h00);
        rblk(8'h0e);
        wblk(8'h08, 1, 8'h00);
        rblk(8'h03);
        repeat (10) @(posedge sys_clk);
        cmp("left", 16'h0000, 16'(rq.size() + uq.size()));
        summarize();
    end
endmodule
